// ### rtl/ext_mem_pkg.sv
package ext_mem_pkg;
  // Clock and timing, times in picoseconds
  localparam int CLK_PS = 25000;
  localparam int AS_LOW_PS = 55000;
  localparam int AS_TO_DS_PS = 65000;
  localparam int DS_READ_PS = 200000;
  localparam int DS_WRITE_PS = 110000;
  localparam int DS_RECOVER_PS = 55000;
  localparam int INPUT_CLOCK_PERIOD_PS = 62500;
  localparam int EXT_TIMING_PS = 2 * INPUT_CLOCK_PERIOD_PS;
  // Least times round up to whole cycles
  localparam int AS_LOW_CYC = (AS_LOW_PS + CLK_PS - 1) / CLK_PS;
  localparam int AS_TO_DS_CYC = (AS_TO_DS_PS + CLK_PS - 1) / CLK_PS;
  localparam int DS_READ_CYC = (DS_READ_PS + CLK_PS - 1) / CLK_PS;
  localparam int DS_WRITE_CYC = (DS_WRITE_PS + CLK_PS - 1) / CLK_PS;
  localparam int DS_RECOVER_CYC = (DS_RECOVER_PS + CLK_PS - 1) / CLK_PS;
  localparam int EXT_TIMING_CYC = (EXT_TIMING_PS + CLK_PS - 1) / CLK_PS;

  // APB byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] P1_DIR_OFS = 8'h04;
  localparam logic [7:0] P1_OUT_OFS = 8'h08;
  localparam logic [7:0] P1_IN_OFS = 8'h0C;
  localparam logic [7:0] ADDR_OFS = 8'h10;
  localparam logic [7:0] WDATA_OFS = 8'h14;
  localparam logic [7:0] CMD_OFS = 8'h18;
  localparam logic [7:0] RDATA_OFS = 8'h1C;

  // Control register fields
  localparam int MODE_LSB = 0;
  localparam int OPEN_DRAIN_BIT = 2;
  localparam int EXT_TIMING_BIT = 3;
  localparam int DM_ENABLE_BIT = 4;
  localparam int PROTECT_BIT = 5;
  localparam int EXEC_EXTERNAL_BIT = 6;
  localparam int P0_ADDR_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MODE_IO = 2'h0;
  localparam logic [1:0] MODE_ADDR_DATA = 2'h1;
  localparam logic [1:0] MODE_HANDSHAKE = 2'h2;

  // Command fields (write) and status fields (read)
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_DATA_SPACE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BLOCKED_BIT = 1;
  localparam int STAT_HS_PEND_BIT = 2;
  localparam int STAT_INTERNAL_BIT = 3;

  // One external access request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic isWrite;
    logic dataSpace;
  } access_req_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ADDR = 3'b001,
    SEQ_AHOLD = 3'b010,
    SEQ_DATA = 3'b011,
    SEQ_RECOVER = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT_READY = 2'b01,
    HS_WAIT_RELEASE = 2'b10
  } hs_state_t;
endpackage

// ### rtl/port1_pad_ctrl.sv
`timescale 1ns/100ps
module port1_pad_ctrl
  import ext_mem_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] value,
  input wire logic [WIDTH-1:0] drive,
  input wire logic openDrain,
  output logic [WIDTH-1:0] padOut,
  output logic [WIDTH-1:0] padOe
);
  // Per line: open drain only ever drives low, releasing for a one
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_line
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          padOut[i] <= 1'b0;
          padOe[i] <= 1'b0;
        end
        else
        begin
          padOut[i] <= value[i];
          padOe[i] <= drive[i] & (~openDrain | ~value[i]);
        end
      end
    end
  endgenerate
endmodule

// ### rtl/ext_access_seq.sv
`timescale 1ns/100ps
module ext_access_seq
  import ext_mem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire access_req_t req,
  input wire logic extTiming,
  input wire logic [7:0] busIn,
  output logic addressStrobe_n,
  output logic dataStrobe_n,
  output logic readWrite,
  output logic dataMemSelect_n,
  output logic [7:0] busOut,
  output logic busDrive,
  output logic [7:0] addrHigh,
  output logic [7:0] readData,
  output logic busy,
  output logic done
);
  seq_state_t state_reg;
  logic [3:0] count_reg;
  logic [3:0] dsLen;

  // Stretch the data strobe by two input clock periods when asked
  always_comb
  begin
    dsLen = req.isWrite ? 4'(DS_WRITE_CYC) : 4'(DS_READ_CYC);
    if (extTiming)
      dsLen = dsLen + 4'(EXT_TIMING_CYC);
  end

  // Phase sequencing; request must stay stable while busy
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg <= SEQ_IDLE;
      count_reg <= 4'h0;
    end
    else if (state_reg == SEQ_IDLE)
    begin
      count_reg <= 4'h1;
      if (start)
        state_reg <= SEQ_ADDR;
    end
    else
    begin
      count_reg <= count_reg + 4'h1;
      case (state_reg)
        SEQ_ADDR:
          if (count_reg == 4'(AS_LOW_CYC))
          begin
            state_reg <= SEQ_AHOLD;
            count_reg <= 4'h1;
          end
        SEQ_AHOLD:
          if (count_reg == 4'(AS_TO_DS_CYC))
          begin
            state_reg <= SEQ_DATA;
            count_reg <= 4'h1;
          end
        SEQ_DATA:
          if (count_reg == dsLen)
          begin
            state_reg <= SEQ_RECOVER;
            count_reg <= 4'h1;
          end
        SEQ_RECOVER:
          if (count_reg == 4'(DS_RECOVER_CYC))
            state_reg <= SEQ_IDLE;
        default:
          state_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Strobes: address strobe low during address phase, then data strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      addressStrobe_n <= 1'b1;
      dataStrobe_n <= 1'b1;
    end
    else
    begin
      addressStrobe_n <= !((state_reg == SEQ_IDLE && start) ||
        (state_reg == SEQ_ADDR && count_reg != 4'(AS_LOW_CYC)));
      dataStrobe_n <= !((state_reg == SEQ_AHOLD &&
        count_reg == 4'(AS_TO_DS_CYC)) ||
        (state_reg == SEQ_DATA && count_reg != dsLen));
    end
  end

  // Qualifiers set with the address, held through recovery
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      readWrite <= 1'b1;
      dataMemSelect_n <= 1'b1;
      addrHigh <= 8'h00;
    end
    else if (state_reg == SEQ_IDLE && start)
    begin
      readWrite <= !req.isWrite;
      dataMemSelect_n <= !req.dataSpace;
      addrHigh <= req.addr[15:8];
    end
    else if (state_reg == SEQ_RECOVER && count_reg == 4'(DS_RECOVER_CYC))
    begin
      readWrite <= 1'b1;
      dataMemSelect_n <= 1'b1; // Idle reads as program space
    end
  end

  // Multiplexed bus: low address byte, then write data or float
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      busOut <= 8'h00;
      busDrive <= 1'b0;
    end
    else if (state_reg == SEQ_IDLE && start)
    begin
      busOut <= req.addr[7:0];
      busDrive <= 1'b1;
    end
    else if (state_reg == SEQ_ADDR && count_reg == 4'(AS_LOW_CYC))
    begin
      busOut <= req.wdata;
      busDrive <= req.isWrite;
    end
    else if (state_reg == SEQ_RECOVER && count_reg == 4'(DS_RECOVER_CYC))
      busDrive <= 1'b0;
  end

  // Read data captured on the last data-strobe cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      readData <= 8'h00;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (state_reg == SEQ_DATA && count_reg == dsLen && !req.isWrite)
        readData <= busIn;
      done <= state_reg == SEQ_RECOVER &&
        count_reg == 4'(DS_RECOVER_CYC);
      busy <= (state_reg == SEQ_IDLE) ? start :
        !(state_reg == SEQ_RECOVER && count_reg == 4'(DS_RECOVER_CYC));
    end
  end
endmodule

// ### rtl/port1_external_memory_interface.sv
// Contract
// - Port 1 is 8 lines, each input or output, or a multiplexed bus.
// - Beyond 256 locations, Port 0 carries upper address, Port 1 low byte.
// - Port 1 outputs globally push-pull or open-drain; inputs hysteretic.
// - Handshake mode: port3_line3 is ready, port3_line4 is data available.
// - Optional active-low data memory select on port3_line4.
// - Program constant load keeps select high; external data load drives low.
// - With internal program memory, data space starts at 4096/8192/16384.
// - Program and data may share space; select is the only qualifier.
// - Extended timing lengthens each access by two input clock periods.
// - Protected and running externally: loads cannot read internal memory.
// - Protected and running internally: loads may read internal memory.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module port1_external_memory_interface
  import ext_mem_pkg::*;
#(
  parameter logic [15:0] INTERNAL_ROM_BYTES = 16'h1000,
  parameter logic ROMLESS = 1'b0
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port1In,
  output logic [7:0] port1Out,
  output logic [7:0] port1Oe,
  output logic [7:0] port0Out,
  output logic port0Oe,
  input wire logic port3Line3,
  output logic port3Line4,
  output logic addressStrobe_n,
  output logic dataStrobe_n,
  output logic readWrite,
  output logic [15:0] romAddr,
  input wire logic [7:0] romData
);
  logic [7:0] ctrl_reg;
  logic [7:0] p1Dir_reg;
  logic [7:0] p1Data_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic isWrite_reg;
  logic dataSpace_reg;
  logic [7:0] rdata_reg;
  logic blocked_reg;
  logic internal_reg;
  logic internalRead_reg;
  hs_state_t hs_reg;
  logic dav_n_reg;
  logic start;
  logic access;
  logic wrEn;
  logic badAccess;
  logic isInternal;
  logic [31:0] readMux;
  logic [1:0] mode;
  access_req_t req;
  logic seqDm_n;
  logic [7:0] seqBus;
  logic seqDrive;
  logic [7:0] seqHigh;
  logic [7:0] seqRead;
  logic seqBusy;
  logic seqDone;
  logic [7:0] padValue;
  logic [7:0] padDrive;

  assign mode = ctrl_reg[MODE_LSB +: 2];
  assign access = psel && penable && !pready;
  assign wrEn = access && pwrite && !badAccess;
  assign req = '{addr: addr_reg, wdata: wdata_reg,
    isWrite: isWrite_reg, dataSpace: dataSpace_reg};

  // Internal program memory covers the low addresses unless romless
  assign isInternal = !ROMLESS && !dataSpace_reg &&
    addr_reg < INTERNAL_ROM_BYTES;

  // Commands are refused while busy or outside address/data mode
  always_comb
  begin
    badAccess = 1'b0;
    case (paddr)
      CTRL_OFS, P1_DIR_OFS, P1_OUT_OFS, P1_IN_OFS, ADDR_OFS, WDATA_OFS,
      RDATA_OFS:
        badAccess = 1'b0;
      CMD_OFS:
        badAccess = pwrite &&
          (seqBusy || mode != MODE_ADDR_DATA);
      default:
        badAccess = 1'b1;
    endcase
  end

  // Software-visible read data
  always_comb
  begin
    readMux = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: readMux[7:0] = ctrl_reg;
      P1_DIR_OFS: readMux[7:0] = p1Dir_reg;
      P1_OUT_OFS: readMux[7:0] = p1Data_reg;
      P1_IN_OFS: readMux[7:0] = port1In;
      ADDR_OFS: readMux[15:0] = addr_reg;
      WDATA_OFS: readMux[7:0] = wdata_reg;
      CMD_OFS:
      begin
        readMux[STAT_BUSY_BIT] = seqBusy || start;
        readMux[STAT_BLOCKED_BIT] = blocked_reg;
        readMux[STAT_HS_PEND_BIT] = hs_reg != HS_IDLE;
        readMux[STAT_INTERNAL_BIT] = internal_reg;
      end
      RDATA_OFS: readMux[7:0] = rdata_reg;
      default: readMux = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait state, then ready with data or error
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && badAccess;
      prdata <= (access && !pwrite && !badAccess) ? readMux : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= CTRL_RESET;
      p1Dir_reg <= 8'h00;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end
    else if (wrEn && !seqBusy)
    begin
      // Address and data are frozen while a bus cycle runs
      case (paddr)
        CTRL_OFS: ctrl_reg <= pwdata[7:0];
        P1_DIR_OFS: p1Dir_reg <= pwdata[7:0];
        ADDR_OFS: addr_reg <= pwdata[15:0];
        WDATA_OFS: wdata_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Port 1 output data; in handshake mode a write also opens a transfer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      p1Data_reg <= 8'h00;
    else if (wrEn && paddr == P1_OUT_OFS &&
      !(mode == MODE_HANDSHAKE && hs_reg != HS_IDLE))
      p1Data_reg <= pwdata[7:0];
  end

  // Command launch: internal reads never reach the bus, protected or not
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      isWrite_reg <= 1'b0;
      dataSpace_reg <= 1'b0;
      start <= 1'b0;
      internalRead_reg <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      internalRead_reg <= 1'b0;
      if (wrEn && paddr == CMD_OFS)
      begin
        isWrite_reg <= pwdata[CMD_WRITE_BIT];
        dataSpace_reg <= pwdata[CMD_DATA_SPACE_BIT];
        internalRead_reg <= 1'b1;
      end
      else if (internalRead_reg && !(isInternal && !isWrite_reg))
        start <= 1'b1;
    end
  end

  // Memory address follows the address register every cycle, so the
  // combinational memory answer has settled before it is captured
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      romAddr <= 16'h0000;
    else
      romAddr <= addr_reg;
  end

  // Result of the last access
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 8'h00;
      blocked_reg <= 1'b0;
      internal_reg <= 1'b0;
    end
    else if (internalRead_reg)
    begin
      internal_reg <= isInternal && !isWrite_reg;
      blocked_reg <= 1'b0;
      if (isInternal && !isWrite_reg)
      begin
        if (ctrl_reg[PROTECT_BIT] && ctrl_reg[EXEC_EXTERNAL_BIT])
        begin
          blocked_reg <= 1'b1;
          rdata_reg <= 8'h00;
        end
        else
          rdata_reg <= romData;
      end
    end
    else if (seqDone && !isWrite_reg)
      rdata_reg <= seqRead;
  end

  // Handshake: data available low until ready answers, then released
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hs_reg <= HS_IDLE;
      dav_n_reg <= 1'b1;
    end
    else if (mode != MODE_HANDSHAKE)
    begin
      hs_reg <= HS_IDLE;
      dav_n_reg <= 1'b1;
    end
    else
    begin
      case (hs_reg)
        HS_IDLE:
          if (wrEn && paddr == P1_OUT_OFS)
          begin
            hs_reg <= HS_WAIT_READY;
            dav_n_reg <= 1'b0;
          end
        HS_WAIT_READY:
          if (!port3Line3)
          begin
            hs_reg <= HS_WAIT_RELEASE;
            dav_n_reg <= 1'b1;
          end
        HS_WAIT_RELEASE:
          if (port3Line3)
            hs_reg <= HS_IDLE;
        default:
          hs_reg <= HS_IDLE;
      endcase
    end
  end

  // Shared port3_line4: data select outranks handshake in bus mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      port3Line4 <= 1'b1;
    else if (mode == MODE_ADDR_DATA && ctrl_reg[DM_ENABLE_BIT])
      port3Line4 <= seqDm_n;
    else if (mode == MODE_HANDSHAKE)
      port3Line4 <= dav_n_reg;
    else
      port3Line4 <= 1'b1;
  end

  // Upper address on Port 0 only when enabled in bus mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port0Out <= 8'h00;
      port0Oe <= 1'b0;
    end
    else
    begin
      port0Out <= seqHigh;
      port0Oe <= mode == MODE_ADDR_DATA && ctrl_reg[P0_ADDR_BIT];
    end
  end

  // Port 1 source: sequencer in bus mode, data register otherwise
  always_comb
  begin
    if (mode == MODE_ADDR_DATA)
    begin
      padValue = seqBus;
      padDrive = {8{seqDrive}};
    end
    else
    begin
      padValue = p1Data_reg;
      padDrive = p1Dir_reg;
    end
  end

  ext_access_seq u_seq (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(start),
    .req(req),
    .extTiming(ctrl_reg[EXT_TIMING_BIT]),
    .busIn(port1In),
    .addressStrobe_n(addressStrobe_n),
    .dataStrobe_n(dataStrobe_n),
    .readWrite(readWrite),
    .dataMemSelect_n(seqDm_n),
    .busOut(seqBus),
    .busDrive(seqDrive),
    .addrHigh(seqHigh),
    .readData(seqRead),
    .busy(seqBusy),
    .done(seqDone)
  );

  port1_pad_ctrl #(
    .WIDTH(8)
  ) u_pad (
    .mclk(mclk),
    .rst_n(rst_n),
    .value(padValue),
    .drive(padDrive),
    .openDrain(ctrl_reg[OPEN_DRAIN_BIT]),
    .padOut(port1Out),
    .padOe(port1Oe)
  );
endmodule

// ### tb/port1_ext_mem_sva.sv
`timescale 1ns/100ps
module port1_ext_mem_sva
  import ext_mem_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] port1Out,
  input wire logic [7:0] port1Oe,
  input wire logic port3Line4,
  input wire logic addressStrobe_n,
  input wire logic dataStrobe_n,
  input wire logic readWrite
);
  logic [4:0] dsLen;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Length of the current data strobe pulse, in cycles
  always_ff @(posedge mclk)
  begin
    if (!rst_n || dataStrobe_n)
      dsLen <= 5'h00;
    else
      dsLen <= dsLen + 5'h01;
  end

  // Strobe shapes: extended timing may only add its fixed five cycles
  as_width_a: assert property ($fell(addressStrobe_n) |->
    !addressStrobe_n [*3] ##1 addressStrobe_n)
    else $error("address strobe width wrong");
  as_to_ds_a: assert property ($rose(addressStrobe_n) |->
    dataStrobe_n [*3] ##1 !dataStrobe_n)
    else $error("data strobe does not follow address strobe");
  ds_len_a: assert property ($rose(dataStrobe_n) |->
    (readWrite ? (dsLen == 5'h08 || dsLen == 5'h0D)
    : (dsLen == 5'h05 || dsLen == 5'h0A)))
    else $error("data strobe length wrong");
  read_float_a: assert property (!dataStrobe_n && readWrite |->
    port1Oe == 8'h00)
    else $error("bus driven during read data phase");
  write_data_a: assert property (!dataStrobe_n && !readWrite |->
    $stable(port1Out))
    else $error("write data moved during data strobe");
  rw_setup_a: assert property ($rose(addressStrobe_n) |->
    readWrite == $past(readWrite, 2))
    else $error("read/write not settled before address strobe rise");
  dm_setup_a: assert property ($rose(addressStrobe_n) |->
    port3Line4 == $past(port3Line4, 2))
    else $error("space select not settled before address strobe rise");
  dm_hold_a: assert property (!dataStrobe_n |->
    $stable(port3Line4))
    else $error("space select moved during data strobe");
  rw_hold_a: assert property ($rose(dataStrobe_n) |->
    ##1 $stable(readWrite) ##1 $stable(readWrite))
    else $error("read/write released too soon after data strobe");
endmodule

bind port1_external_memory_interface port1_ext_mem_sva i_sva (
  .mclk(mclk),
  .rst_n(rst_n),
  .port1Out(port1Out),
  .port1Oe(port1Oe),
  .port3Line4(port3Line4),
  .addressStrobe_n(addressStrobe_n),
  .dataStrobe_n(dataStrobe_n),
  .readWrite(readWrite)
);

// ### tb/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model
  import ext_mem_pkg::*;
#(
  parameter int LAT = 2
)(
  input wire logic mclk,
  input wire logic addressStrobe_n,
  input wire logic dataStrobe_n,
  input wire logic readWrite,
  input wire logic dataMemSelect_n,
  input wire logic [7:0] busPin,
  input wire logic [7:0] addrHigh,
  output logic memDrive,
  output logic [7:0] memData
);
  logic [7:0] progMem [0:65535];
  logic [7:0] dataMem [0:65535];
  logic [15:0] lastAddr;
  logic [4:0] dsCnt, lastLen;
  logic lastDm, lastRw, asPrev, dsPrev;

  initial
  begin
    memDrive = 1'h0;
    memData = 8'h00;
    dsCnt = 5'h00;
    asPrev = 1'h1;
    dsPrev = 1'h1;
  end

  // Address and space qualifier are taken as the address strobe rises
  always @(posedge mclk)
  begin
    asPrev <= addressStrobe_n;
    if (addressStrobe_n && !asPrev)
    begin
      lastAddr <= {addrHigh, busPin};
      lastDm <= dataMemSelect_n;
    end
  end

  // Slow memory: read data appears only LAT+1 cycles into the strobe
  always @(posedge mclk)
  begin
    dsPrev <= dataStrobe_n;
    if (!dataStrobe_n)
    begin
      dsCnt <= dsCnt + 5'h01;
      lastRw <= readWrite;
      memDrive <= readWrite && (dsCnt >= LAT);
      memData <= lastDm ? progMem[lastAddr] : dataMem[lastAddr];
    end
    else
    begin
      memDrive <= 1'h0;
      dsCnt <= 5'h00;
      if (!dsPrev)
      begin
        lastLen <= dsCnt;
        if (!lastRw && lastDm)
          progMem[lastAddr] <= busPin;
        else if (!lastRw)
          dataMem[lastAddr] <= busPin;
      end
    end
  end
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb
  import ext_mem_pkg::*;
();
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, port1In, port1Out, port1Oe, port0Out, extLevel;
  logic [31:0] pwdata, prdata, rdat, st, ctl, cyc;
  logic port0Oe, port3Line3, port3Line4, ioOn, memDrive;
  logic addressStrobe_n, dataStrobe_n, readWrite;
  logic [15:0] romAddr;
  logic [7:0] romData, memData, ioVal;
  int fail_count, n_checks, n;

  always #12.5 mclk = ~mclk;

  // Pins: device drivers win, else memory, else outside level or noise
  assign romData = romAddr[7:0] ^ romAddr[15:8] ^ 8'h3C;
  assign extLevel = memDrive ? memData : (ioOn ? ioVal : cyc[7:0] ^ 8'h55);
  assign port1In = (port1Oe & port1Out) | (~port1Oe & extLevel);

  port1_external_memory_interface i_port1_external_memory_interface (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port1In(port1In),
    .port1Out(port1Out), .port1Oe(port1Oe), .port0Out(port0Out),
    .port0Oe(port0Oe), .port3Line3(port3Line3), .port3Line4(port3Line4),
    .addressStrobe_n(addressStrobe_n), .dataStrobe_n(dataStrobe_n),
    .readWrite(readWrite), .romAddr(romAddr), .romData(romData));

  ext_mem_model i_ext_mem_model (
    .mclk(mclk), .addressStrobe_n(addressStrobe_n),
    .dataStrobe_n(dataStrobe_n), .readWrite(readWrite),
    .dataMemSelect_n(port3Line4), .busPin(port1In),
    .addrHigh(port0Out & {8{port0Oe}}), .memDrive(memDrive),
    .memData(memData));

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1)
      @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rdat, err);
  endtask

  // Launch one access, poll busy, then fetch the read data
  task ext_op(input logic w, input logic sp, input logic [15:0] a,
    input logic [7:0] d);
    wr(ADDR_OFS, {16'h0000, a});
    wr(WDATA_OFS, {24'h000000, d});
    wr(CMD_OFS, {30'h00000000, sp, w});
    st = 32'h00000001;
    while (st[STAT_BUSY_BIT] !== 1'h0)
      apb(1'h0, CMD_OFS, 32'h00000000, st, err);
    apb(1'h0, RDATA_OFS, 32'h00000000, rdat, err);
  endtask

  task wait_p34(input logic v);
    n = 0;
    while (port3Line4 !== v && n < 10)
    begin
      @(posedge mclk);
      n++;
    end
  endtask

  // Cycle counter; the ceiling cuts a hang short
  always @(posedge mclk)
  begin
    cyc <= cyc + 32'h00000001;
    if (cyc == 32'h00004E20)
    begin
      fail_count++;
      final_report;
    end
  end

  initial
  begin
    mclk = 1'h0;
    rst_n = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {port3Line3, ioOn, ioVal, cyc} = {2'h2, 8'h3C, 32'h0};
    fail_count = 0;
    n_checks = 0;
    i_ext_mem_model.progMem[16'h1000] = 8'h11;
    i_ext_mem_model.dataMem[16'h1000] = 8'h22;
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    chk({port1Oe, port3Line4, dataStrobe_n, readWrite}, 11'h007);
    ioOn <= 1'h1;
    wr(CTRL_OFS, 32'h00000000);
    wr(P1_DIR_OFS, 32'h0000000F);
    wr(P1_OUT_OFS, 32'h000000A5);
    apb(1'h0, P1_IN_OFS, 32'h00000000, rdat, err);
    chk(rdat, 32'h00000035);
    wr(CTRL_OFS, 32'h00000001 << OPEN_DRAIN_BIT);
    wr(P1_DIR_OFS, 32'h000000FF);
    repeat (2) @(posedge mclk);
    chk(port1Oe, 8'h5A);
    wr(CTRL_OFS, 32'h00000000);
    ioOn <= 1'h0;
    apb(1'h1, CMD_OFS, 32'h00000000, rdat, err);
    chk(err, 1'h1);
    // Unmapped offset: error flag and zero data, checked one by one
    apb(1'h0, 8'h20, 32'h00000000, rdat, err);
    chk(err, 1'h1);
    chk(rdat, 32'h00000000);
    // Same address in both spaces; select off on the last two passes
    for (int i = 0; i < 6; i++)
    begin
      ctl = 32'(MODE_ADDR_DATA) | (32'h00000001 << P0_ADDR_BIT);
      ctl = ctl | (32'(i < 4) << DM_ENABLE_BIT);
      ctl = ctl | (32'(i[1]) << EXT_TIMING_BIT);
      wr(CTRL_OFS, ctl);
      ext_op(1'h0, i[0], 16'h1000, 8'h00);
      chk(rdat, (i[0] && i < 4) ? 32'h00000022 : 32'h00000011);
      chk(i_ext_mem_model.lastAddr, 16'h1000);
      chk(i_ext_mem_model.lastDm, !(i[0] && i < 4));
      chk(i_ext_mem_model.lastLen,
        DS_READ_CYC + (i[1] ? EXT_TIMING_CYC : 0));
      chk(i_ext_mem_model.lastRw, 1'h1);
    end
    wr(CTRL_OFS, ctl | (32'h00000001 << DM_ENABLE_BIT));
    ext_op(1'h1, 1'h1, 16'h3456, 8'h77);
    chk(i_ext_mem_model.dataMem[16'h3456], 8'h77);
    chk({i_ext_mem_model.lastRw, i_ext_mem_model.lastDm},
      2'h0);
    chk(i_ext_mem_model.lastLen, DS_WRITE_CYC);
    // Internal program space: open, protected from outside, protected inside
    for (int j = 0; j < 3; j++)
    begin
      ctl = 32'(MODE_ADDR_DATA) | (32'(j > 0) << PROTECT_BIT);
      wr(CTRL_OFS, ctl | (32'(j == 1) << EXEC_EXTERNAL_BIT));
      ext_op(1'h0, 1'h0, 16'h0123, 8'h00);
      chk(rdat,
        (j == 1) ? 32'h0 : 32'(8'h01 ^ 8'h23 ^ 8'h3C));
      chk(st[STAT_BLOCKED_BIT], j == 1);
      chk(st[STAT_INTERNAL_BIT], 1'h1);
    end
    wr(CTRL_OFS, 32'(MODE_HANDSHAKE));
    wr(P1_DIR_OFS, 32'h000000FF);
    wr(P1_OUT_OFS, 32'h0000005A);
    wait_p34(1'h0);
    chk({port3Line4, port1Out}, 9'h05A);
    port3Line3 <= 1'h0;
    wait_p34(1'h1);
    chk(port3Line4, 1'h1);
    port3Line3 <= 1'h1;
    repeat (4) @(posedge mclk);
    final_report;
  end
endmodule
